/* rtl/mci_pkg.sv */
/*
 * Package for the motion command interpreter: frame layout, instruction
 * and type codes, status codes, reset values and packed carriers.
 * Assumes one 10 MHz clock and that frames arrive already byte-framed.
 */
// Overview of operation
// - Rotate-left turns the motor toward decreasing position at the given velocity
// - Rotate-left selects velocity mode first, then writes target velocity
// - Rotate-left frame: instruction 2, type 0, bank 0, signed velocity value
// - Motor-stop performs a soft, decelerated stop
// - Motor-stop selects velocity mode, then sets target speed to zero
// - Motor-stop frame: instruction 3, type, bank and value all zero
// - Move-to-position uses the programmed ramp and positioning speed
// - Move reply with status 100 is sent right after setup, not after motion
// - Further commands are accepted while a positioning move runs
// - Move targets and offsets are full 32-bit signed values
// - Stop or rotate commands abandon a running positioning move
// - Move type selects absolute, relative offset or stored coordinate
// - Relative mode adds offset to actual position; host keeps it in range
// - Coordinate mode moves to the stored coordinate selected by value
// - Distances over 2^31-1 wrap, taking the shorter opposite path
// - Move writes the resolved position into the target position parameter
`default_nettype none

package mci_pkg;
    localparam int FRAME_BYTES = 9;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_INSTR = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_BANK = 4'h3;
    localparam logic [3:0] IDX_SUM = 4'h8;
    localparam logic [7:0] INSTR_ROTATE_RIGHT = 8'h01;
    localparam logic [7:0] INSTR_ROTATE_LEFT = 8'h02;
    localparam logic [7:0] INSTR_MOTOR_STOP = 8'h03;
    localparam logic [7:0] INSTR_MOVE = 8'h04;
    localparam logic [7:0] TYPE_ABSOLUTE = 8'h00;
    localparam logic [7:0] TYPE_RELATIVE = 8'h01;
    localparam logic [7:0] TYPE_STORED_COORDINATE_TYPE = 8'h02;
    localparam logic [7:0] STATUS_OK = 8'h64;          // 100
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] RST_MODULE_ADDR = 8'h01;
    localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    localparam logic [3:0] RST_IDX = 4'h0;

    typedef enum logic [1:0] {
        MCI_RAMP_POSITION,
        MCI_RAMP_VELOCITY,
        MCI_RAMP_HOLD
    } mci_ramp_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] ctype;
        logic [7:0] bank;
        logic [31:0] value;
    } mci_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] status;
        logic [7:0] instr;
        logic [31:0] value;
    } mci_reply_t;

    typedef struct packed {
        mci_ramp_t ramp_mode;
        logic signed [31:0] target_velocity;
        logic signed [31:0] target_position;
    } mci_axis_t;
endpackage : mci_pkg

`default_nettype wire

/* rtl/mci_interpreter.sv */
/*
 * Motion command interpreter: collects nine-byte command frames, checks the
 * checksum, decodes rotate-left, rotate-right, motor-stop and move commands,
 * updates the axis parameters and issues a status reply.
 * Assumes byte strobes from a same-clock receiver, the actual position and
 * the stored coordinate table supplied by logic on the same clock.
 */
`default_nettype none

module mci_interpreter
    import mci_pkg::*;
#(
    parameter int STORED_COORDINATE_TYPE_AW = 5   // Stored coordinate index width
)
(
    input wire logic clk,                       // 10 MHz system clock
    input wire logic sys_rst,                   // Async reset, active high
    input wire logic rx_valid,                  // Command byte strobe
    input wire logic [7:0] rx_byte,             // Command byte
    input wire logic signed [31:0] actual_pos,  // Actual motor position
    input wire logic signed [31:0] stored_coordinate_type_data,  // Stored coordinate data
    output logic [STORED_COORDINATE_TYPE_AW-1:0] stored_coordinate_type_index,    // Stored coordinate select
    output mci_axis_t axis,                     // Axis parameters
    output logic axis_write,                    // Axis parameters updated
    output logic reply_valid,                   // Reply pulse
    output mci_reply_t reply                    // Reply contents
);

    typedef enum logic [1:0] {
        MCI_COLLECT,
        MCI_EXECUTE,
        MCI_STORED_COORDINATE_TYPE_WAIT
    } mci_state_t;

    mci_state_t state, next_state;
    logic [3:0] idx, next_idx;
    logic [7:0] sum, next_sum;
    mci_frame_t frame, next_frame;
    logic sum_ok, next_sum_ok;
    logic [STORED_COORDINATE_TYPE_AW-1:0] next_stored_coordinate_type_index;
    mci_axis_t next_axis;
    logic next_axis_write;
    logic next_reply_valid;
    mci_reply_t next_reply;

    // Builds a reply for the current frame with the given status
    function automatic mci_reply_t make_reply(input mci_frame_t f,
                                              input logic [7:0] st);
        mci_reply_t r;
        r.addr = f.addr;
        r.status = st;
        r.instr = f.instr;
        r.value = RST_ZERO32;
        return r;
    endfunction

    // Velocity-mode update shared by both rotate commands and the stop;
    // mode and speed go out in one write so the ramp never sees a stale
    // speed in the new mode
    function automatic mci_axis_t velocity_update(input mci_axis_t a,
                                                  input logic [31:0] v);
        mci_axis_t r;
        r = a;
        r.ramp_mode = MCI_RAMP_VELOCITY;
        r.target_velocity = v;
        return r;
    endfunction

    // Positioning update shared by all move types; the ramp limits and
    // the positioning speed are left as programmed
    function automatic mci_axis_t position_update(input mci_axis_t a,
                                                  input logic [31:0] p);
        mci_axis_t r;
        r = a;
        r.ramp_mode = MCI_RAMP_POSITION;
        r.target_position = p;
        return r;
    endfunction

    // A checked move to a coordinate that exists in the table; both the
    // sequencer and the reply logic need it, so it is decoded in one place
    function automatic logic stored_coordinate_type_move(input mci_frame_t f,
                                        input logic ok);
        return ok && f.instr == INSTR_MOVE && f.ctype == TYPE_STORED_COORDINATE_TYPE &&
            f.value < 32'(1 << STORED_COORDINATE_TYPE_AW);
    endfunction

    // Byte collection. The running sum lets the checksum byte be judged
    // with one compare. There is no byte timeout, so a lost byte shifts
    // the framing of later frames until reset.
    always_comb
    begin
        next_idx = idx;
        next_sum = sum;
        next_frame = frame;
        next_sum_ok = sum_ok;
        if (state == MCI_COLLECT && rx_valid)
        begin
            // Value bytes arrive most significant first
            case (idx)
                IDX_ADDR: next_frame.addr = rx_byte;
                IDX_INSTR: next_frame.instr = rx_byte;
                IDX_TYPE: next_frame.ctype = rx_byte;
                IDX_BANK: next_frame.bank = rx_byte;
                IDX_SUM: next_frame = frame;
                default:
                    next_frame.value = {frame.value[23:0], rx_byte};
            endcase
            if (idx == IDX_SUM)
            begin
                next_sum_ok = (rx_byte == sum);
                next_idx = RST_IDX;
                next_sum = RST_ZERO8;
            end
            else
            begin
                next_sum = sum + rx_byte;
                next_idx = idx + 4'h1;
            end
        end
    end

    // Collection registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idx <= RST_IDX;
            sum <= RST_ZERO8;
            frame <= '0;
            sum_ok <= 1'b0;
        end
        else
        begin
            idx <= next_idx;
            sum <= next_sum;
            frame <= next_frame;
            sum_ok <= next_sum_ok;
        end
    end

    // Sequencer: one execute cycle after the checksum byte, plus a wait
    // cycle for the coordinate table, whose entry is read one cycle after
    // its index is set. Collection resumes after the execute or wait cycle,
    // so no move blocks a later command
    always_comb
    begin
        next_state = state;
        next_stored_coordinate_type_index = stored_coordinate_type_index;
        case (state)
            MCI_COLLECT:
                if (rx_valid && idx == IDX_SUM)
                    next_state = MCI_EXECUTE;
            MCI_EXECUTE:
            begin
                next_state = MCI_COLLECT;
                if (stored_coordinate_type_move(frame, sum_ok))
                begin
                    // Table index for the stored coordinate
                    next_stored_coordinate_type_index = frame.value[STORED_COORDINATE_TYPE_AW-1:0];
                    next_state = MCI_STORED_COORDINATE_TYPE_WAIT;
                end
            end
            MCI_STORED_COORDINATE_TYPE_WAIT:
                next_state = MCI_COLLECT;
            default:
                next_state = MCI_COLLECT;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= MCI_COLLECT;
            stored_coordinate_type_index <= '0;
        end
        else
        begin
            state <= next_state;
            stored_coordinate_type_index <= next_stored_coordinate_type_index;
        end
    end

    // Decode and axis update. Every accepted velocity command replaces
    // the whole velocity setting, which also abandons a running
    // positioning move
    always_comb
    begin
        next_axis = axis;
        next_axis_write = 1'b0;
        next_reply_valid = 1'b0;
        next_reply = reply;
        case (state)
            MCI_EXECUTE:
            begin
                next_reply_valid = 1'b1;
                if (!sum_ok)
                    next_reply = make_reply(frame, STATUS_BAD_SUM);
                else
                begin
                    next_reply = make_reply(frame, STATUS_OK);
                    case (frame.instr)
                        INSTR_ROTATE_LEFT:
                        begin
                            // Velocity mode first, then the speed, in one
                            // update
                            // Negative velocity decrements position
                            next_axis = velocity_update(axis, -frame.value);
                            next_axis_write = 1'b1;
                        end
                        INSTR_ROTATE_RIGHT:
                        begin
                            next_axis = velocity_update(axis, frame.value);
                            next_axis_write = 1'b1;
                        end
                        INSTR_MOTOR_STOP:
                        begin
                            // Zero speed in velocity mode lets the ramp
                            // decelerate softly
                            next_axis = velocity_update(axis, RST_ZERO32);
                            next_axis_write = 1'b1;
                        end
                        INSTR_MOVE:
                        begin
                            // Type picks the target source
                            case (frame.ctype)
                                TYPE_ABSOLUTE:
                                begin
                                    // Full signed range
                                    next_axis = position_update(axis,
                                        frame.value);
                                    next_axis_write = 1'b1;
                                end
                                TYPE_RELATIVE:
                                begin
                                    // 32-bit wrap gives the shorter path;
                                    next_axis = position_update(axis,
                                        actual_pos + frame.value);
                                    next_axis_write = 1'b1;
                                end
                                TYPE_STORED_COORDINATE_TYPE:
                                begin
                                    // The reply waits for the table read
                                    if (stored_coordinate_type_move(frame, sum_ok))
                                        next_reply_valid = 1'b0;
                                    else
                                        next_reply = make_reply(frame,
                                            STATUS_BAD_VALUE);
                                end
                                default:
                                    next_reply = make_reply(frame,
                                        STATUS_BAD_TYPE);
                            endcase
                        end
                        default:
                            next_reply = make_reply(frame, STATUS_BAD_CMD);
                    endcase
                end
            end
            MCI_STORED_COORDINATE_TYPE_WAIT:
            begin
                // Coordinate assumed defined by host
                next_axis = position_update(axis, stored_coordinate_type_data);
                next_axis_write = 1'b1;
                next_reply_valid = 1'b1;
            end
            default:
                next_reply_valid = 1'b0;
        endcase
    end

    // Output registers, so every output comes straight from a flip-flop.
    // The reply goes out on setup and never waits for the motion to
    // finish
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            axis <= '{MCI_RAMP_HOLD, RST_ZERO32, RST_ZERO32};
            axis_write <= 1'b0;
            reply_valid <= 1'b0;
            reply <= '0;
        end
        else
        begin
            axis <= next_axis;
            axis_write <= next_axis_write;
            reply_valid <= next_reply_valid;
            reply <= next_reply;
        end
    end

endmodule // mci_interpreter

`default_nettype wire

/* testbench/mci_stored_coordinate_type_store.sv */
/* Stored coordinate table at the interpreter's far side.
   Assumes a registered index; the entry follows it within the cycle,
   so the interpreter reads it one cycle after setting the index. */
`default_nettype none
module mci_stored_coordinate_type_store
#(
    parameter int STORED_COORDINATE_TYPE_AW = 5 // Index width
)
(
    input wire logic [STORED_COORDINATE_TYPE_AW-1:0] stored_coordinate_type_index, // Select
    output logic signed [31:0] stored_coordinate_type_data // Entry
);
    timeunit 1ns;
    timeprecision 1ns;
    // All entries preset, as if stored by earlier commands
    always_comb
    begin
        stored_coordinate_type_data = 32'ha5c3_0000 | 32'(stored_coordinate_type_index);
    end
endmodule // mci_stored_coordinate_type_store
`default_nettype wire

/* testbench/mci_checker_sva.sv */
/* Port checker for the motion command interpreter.
   Bound from the bench top; sees only the top module's ports. */
`default_nettype none
module mci_checker_sva
    import mci_pkg::*;
#(
    parameter int STORED_COORDINATE_TYPE_AW = 5 // Index width
)
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic rx_valid, // Strobe
    input wire logic [7:0] rx_byte, // Byte
    input wire logic signed [31:0] actual_pos, // Position
    input wire logic signed [31:0] stored_coordinate_type_data, // Entry
    input wire logic [STORED_COORDINATE_TYPE_AW-1:0] stored_coordinate_type_index, // Select
    input wire mci_axis_t axis, // Axis
    input wire logic axis_write, // Update
    input wire logic reply_valid, // Reply pulse
    input wire mci_reply_t reply // Reply
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Update and reply travel together
    a_write_ok: assert property (
        axis_write |-> reply_valid && reply.status == STATUS_OK)
        else $error("axis write without ok reply");
    a_ok_write: assert property (
        reply_valid && reply.status == STATUS_OK |-> axis_write)
        else $error("ok reply without axis write");
    // A frame is nine bytes, so replies are far apart
    a_reply_gap: assert property (
        reply_valid |=> !reply_valid [*8])
        else $error("replies too close");
    a_reply_delay: assert property (
        reply_valid |-> $past(rx_valid, 2) || $past(rx_valid, 3))
        else $error("reply not tied to last byte");
    a_axis_quiet: assert property (
        !axis_write |-> $stable(axis))
        else $error("axis moved without update");
    // Mode written with stop, rotate-left and move commands
    a_stop_zero: assert property (
        axis_write && reply.instr == INSTR_MOTOR_STOP |->
        axis.ramp_mode == MCI_RAMP_VELOCITY && axis.target_velocity == 0)
        else $error("stop left speed or mode wrong");
    a_left_mode: assert property (
        axis_write && reply.instr == INSTR_ROTATE_LEFT |->
        axis.ramp_mode == MCI_RAMP_VELOCITY)
        else $error("rotate without velocity mode");
    a_move_mode: assert property (
        axis_write && reply.instr == INSTR_MOVE |->
        axis.ramp_mode == MCI_RAMP_POSITION)
        else $error("move without position ramp");
endmodule // mci_checker_sva
`default_nettype wire

/* testbench/tb.sv */
/* Self-checking bench for the motion command interpreter.
   Bytes change on falling edges; the coordinate store is a model. */
`default_nettype none
module tb;
    import mci_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STORED_COORDINATE_TYPE_AW = 5;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic signed [31:0] actual_pos = 32'sh0;
    logic signed [31:0] stored_coordinate_type_data;
    logic [STORED_COORDINATE_TYPE_AW-1:0] stored_coordinate_type_index;
    mci_axis_t axis;
    mci_axis_t keep;
    logic axis_write;
    logic reply_valid;
    mci_reply_t reply;
    int bad_count = 0;
    int samples_checked = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    mci_interpreter #(.STORED_COORDINATE_TYPE_AW(STORED_COORDINATE_TYPE_AW)) u_dut (.clk, .sys_rst,
        .rx_valid, .rx_byte, .actual_pos, .stored_coordinate_type_data, .stored_coordinate_type_index,
        .axis, .axis_write, .reply_valid, .reply);
    mci_stored_coordinate_type_store #(.STORED_COORDINATE_TYPE_AW(STORED_COORDINATE_TYPE_AW)) u_store (.stored_coordinate_type_index,
        .stored_coordinate_type_data);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string s);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %0t %s: %h not %h", $time, s, got, exp);
        end
    endtask
    // One frame; lat 0 skips the delay check
    task automatic send(input logic [7:0] ins, typ, input logic [31:0] v,
        input logic bad, input logic [7:0] st, input int lat);
        logic [7:0] b [9];
        int n;
        b = '{8'h01, ins, typ, 8'h00, v[31:24], v[23:16], v[15:8],
            v[7:0], 8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        b[8] ^= {7'h0, bad};
        for (int i = 0; i < 9; i++)
        begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_byte = b[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        // This loop's first falling edge lies in the second cycle after the checksum
        for (n = 2; n <= 9; n++)
        begin
            @(negedge clk);
            if (reply_valid === 1'b1) break;
        end
        if (n > 9)
        begin
            bad_count++;
            $display("mismatch %0t no reply", $time);
            tally_and_finish();
        end
        else
        begin
            if (lat != 0) check(32'(n), 32'(lat), "delay");
            check(reply.status, st, "status");
            check(reply.addr, 8'h01, "addr");
            check(reply.instr, ins, "instr");
            check(reply.value, 32'h0, "rval");
            check(axis_write, st == STATUS_OK, "write");
        end
    endtask
    task automatic t_rotate_stop;
        // Velocities stay inside the host's range
        send(INSTR_ROTATE_LEFT, 8'h00, 32'd1000, 0, STATUS_OK, 2);
        check(axis.target_velocity, -32'sd1000, "left");
        check(axis.ramp_mode, MCI_RAMP_VELOCITY, "lmode");
        send(INSTR_MOVE, TYPE_ABSOLUTE, 32'd500, 0, STATUS_OK, 2);
        send(INSTR_MOTOR_STOP, 8'h00, 32'h0, 0, STATUS_OK, 2);
        check(axis.target_velocity, 32'h0, "stop");
        check(axis.ramp_mode, MCI_RAMP_VELOCITY, "smode");
        send(INSTR_MOVE, TYPE_ABSOLUTE, 32'd600, 0, STATUS_OK, 2);
        send(INSTR_ROTATE_RIGHT, 8'h00, 32'd700, 0, STATUS_OK, 2);
        check(axis.target_velocity, 32'sd700, "right");
        check(axis.ramp_mode, MCI_RAMP_VELOCITY, "rmode");
        $display("test rotate_stop done");
    endtask
    // Reset in mid-run brings every output back to its idle value
    task automatic t_reset;
        @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        check(axis.ramp_mode, MCI_RAMP_HOLD, "rsmode");
        check(axis.target_position, 32'h0, "rspos");
        check(stored_coordinate_type_index, 5'h00, "rsindex");
        check(reply.status, 8'h00, "rsreply");
        sys_rst = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_move_abs;
        logic [31:0] p [3] = '{32'd90000, 32'h8000_0000, 32'h7fff_ffff};
        foreach (p[i])
        begin
            send(INSTR_MOVE, TYPE_ABSOLUTE, p[i], 0, STATUS_OK, 2);
            check(axis.target_position, p[i], "abs");
            check(axis.ramp_mode, MCI_RAMP_POSITION, "amode");
        end
        $display("test move_abs done");
    endtask
    task automatic t_move_rel;
        actual_pos = 32'sd5000;
        send(INSTR_MOVE, TYPE_RELATIVE, -32'sd10000, 0, STATUS_OK, 2);
        check(axis.target_position, -32'sd5000, "rel");
        actual_pos = 32'sh7fff_ffff;
        send(INSTR_MOVE, TYPE_RELATIVE, 32'd2, 0, STATUS_OK, 2);
        check(axis.target_position, 32'h8000_0001, "wrap");
        $display("test move_rel done");
    endtask
    task automatic t_move_stored_coordinate_type;
        send(INSTR_MOVE, TYPE_STORED_COORDINATE_TYPE, 32'd8, 0, STATUS_OK, 3);
        check(axis.target_position, 32'ha5c3_0008, "c8");
        send(INSTR_MOVE, TYPE_STORED_COORDINATE_TYPE, 32'd31, 0, STATUS_OK, 3);
        check(stored_coordinate_type_index, 5'h1f, "index");
        check(axis.target_position, 32'ha5c3_001f, "c31");
        $display("test move_stored_coordinate_type done");
    endtask
    task automatic t_refusals;
        keep = axis;
        send(INSTR_MOVE, TYPE_ABSOLUTE, 32'd7, 1, STATUS_BAD_SUM, 2);
        send(8'h09, 8'h00, 32'd7, 0, STATUS_BAD_CMD, 0);
        send(INSTR_MOVE, 8'h03, 32'd7, 0, STATUS_BAD_TYPE, 0);
        send(INSTR_MOVE, TYPE_STORED_COORDINATE_TYPE, 32'd32, 0, STATUS_BAD_VALUE, 0);
        check(axis.target_position, keep.target_position, "kept");
        $display("test refusals done");
    endtask
    // Reset for three cycles, then the scenarios
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        check(axis.ramp_mode, MCI_RAMP_HOLD, "reset");
        t_rotate_stop();
        t_move_abs();
        t_move_rel();
        t_move_stored_coordinate_type();
        t_reset();
        t_refusals();
        tally_and_finish();
    end
endmodule // tb
bind mci_interpreter mci_checker_sva #(.STORED_COORDINATE_TYPE_AW(STORED_COORDINATE_TYPE_AW)) u_chk (
    .clk, .sys_rst, .rx_valid, .rx_byte, .actual_pos, .stored_coordinate_type_data,
    .stored_coordinate_type_index, .axis, .axis_write, .reply_valid, .reply);
`default_nettype wire
